//--- logic/btc_burst_trigger_controller.sv
/*
  Burst and trigger sequencer: configuration store, trigger sources, delay,
  burst cycle counting, gated bursts, trigger output and completion flag.
  Assumes a waveform engine that pulses cycleEnd at each cycle end and follows
  waveRun and enginePhase; configuration arrives with a one-cycle cfgLoad.
*/
`timescale 1ns/1ns
// Summary of operation
// - Start phase accepted between -360 and +360 degrees, default zero.
// - Phase referenced to shape zero crossing or first point; pulse, noise ignore it.
// - Gate inactive: finish current cycle, then stop holding start-phase level.
// - Burst enable defaults off, reads 0/1, forces sweep and modulation off.
// - Phase written in degrees or radians; display value always degrees.
// - Source selector: internal, external pin, remote; default internal.
// - Internal source launches bursts repeatedly, spaced by the burst period.
// - External source: one burst per selected edge; edges during burst ignored.
// - Remote source: one burst per command; waiting indicator lit meanwhile.
// - External or remote source keep count and phase, ignore period.
// - Waveform waveform_command_a command resets source selector to internal.
// - Pending completion request sets event status bit 0 at burst end.
// - Triggered mode waits programmed delay, 0 to 85 s, default zero.
// - External trigger on rising or falling edge, default rising.
// - Gate input active-high or active-low, default active-high.
// - Enabled trigger output marks burst start with chosen leading edge.
// - Internal source: trigger output half-duty square, period equals burst period.
// - External source or gated kind disables the trigger output.
// - Remote source: trigger output pulse wider than one microsecond per burst.
// - Trigger output enable defaults off, reads back 0 or 1.
// - Burst count 1 to 1,000,000 or infinite, default one.
// - Burst period 1 us to 500 s, default 10 ms.
// - Gated noise stops immediately when gate goes inactive.
module btc_burst_trigger_controller import btc_pkg::*; #(
  parameter logic [PERIOD_W-1:0] PERIOD_DEFAULT = PERIOD_DEFAULT_CYC,
  parameter logic [PERIOD_W-1:0] PERIOD_MAX = PERIOD_MAX_CYC,
  parameter logic [DELAY_W-1:0] DELAY_MAX = DELAY_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration load
  input wire logic cfgLoad,
  input wire logic cfgBurstEnable,
  input wire logic cfgGatedKind,
  input wire logic [1:0] cfgSource,
  input wire logic [COUNT_W-1:0] cfgCount,
  input wire logic cfgCountInfinite,
  input wire logic [PERIOD_W-1:0] cfgInternalBurstPeriod,
  input wire logic [DELAY_W-1:0] cfgDelay,
  input wire logic signed [PHASE_W-1:0] cfgPhase,
  input wire logic cfgUnitRadians,
  input wire logic cfgInputEdgeSelect,
  input wire logic cfgActiveLowGate,
  input wire logic cfgTrigOutEnable,
  input wire logic cfgOutputEdgeSelect,
  input wire logic cfgSweepOn,
  input wire logic cfgModulationOn,
  input wire logic waveformCommandA,
  input wire logic [2:0] waveShape,
  // Trigger and event inputs
  input wire logic extTrigPin,
  input wire logic remoteTrigger,
  input wire logic opcRequest,
  input wire logic eventStatusClear,
  input wire logic cycleEnd,
  // Readback
  output logic burstEnable,
  output logic burstKindSelect,
  output logic [1:0] triggerSource,
  output logic trigOutEnable,
  output logic sweepOn,
  output logic modulationOn,
  output logic signed [PHASE_W-1:0] phaseDegrees,
  // Engine control and status
  output logic signed [PHASE_W-1:0] enginePhase,
  output logic waveRun,
  output logic burstDone,
  output logic waitingForRemote,
  output logic trigOut,
  output logic eventStatusOpc
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_RUN, ST_GATE_RUN, ST_GATE_FINISH
  } btc_state_t;

  btc_state_t state;
  logic [COUNT_W-1:0] burstCount;
  logic countInfinite;
  logic [PERIOD_W-1:0] internalBurstPeriod;
  logic [DELAY_W-1:0] trigDelay;
  logic inputEdgeSelect;
  logic activeLowGate;
  logic outputEdgeSelect;
  logic [PERIOD_W-1:0] unusedLow;
  logic signed [PHASE_W-1:0] next_phaseDegrees;
  logic signed [32:0] radProduct;
  logic signed [PHASE_W-1:0] rawDeg;
  logic [COUNT_W-1:0] next_count;
  logic [PERIOD_W-1:0] next_period;
  logic extSync;
  logic extPrev;
  logic extEdge;
  logic gateActive;
  logic triggeredOn;
  logic fire;
  logic burstStart;
  logic [PERIOD_W-1:0] periodCount;
  logic [PERIOD_W-1:0] squareCount;
  logic squareRunning;
  logic [4:0] pulseCount;
  logic [COUNT_W-1:0] cyclesDone;
  logic [DELAY_W-1:0] delayCount;
  logic opcPending;
  logic trigActive;
  logic trigAllowed;

  assign unusedLow = 34'h0;

  // Phase conversion and range limit
  always_comb begin
    radProduct = cfgPhase * RAD_TO_DEG_MUL;
    rawDeg = cfgUnitRadians ? PHASE_W'(radProduct >>> RAD_FRAC) : cfgPhase;
    if (rawDeg > PHASE_MAX) begin
      next_phaseDegrees = PHASE_MAX;
    end else if (rawDeg < -PHASE_MAX) begin
      next_phaseDegrees = -PHASE_MAX;
    end else begin
      next_phaseDegrees = rawDeg;
    end
  end

  // Count and period limits
  always_comb begin
    if (cfgCount == unusedLow[COUNT_W-1:0]) begin
      next_count = COUNT_DEFAULT;
    end else if (cfgCount > COUNT_MAX) begin
      next_count = COUNT_MAX;
    end else begin
      next_count = cfgCount;
    end
    if (cfgInternalBurstPeriod < PERIOD_MIN_CYC) begin
      next_period = PERIOD_MIN_CYC;
    end else if (cfgInternalBurstPeriod > PERIOD_MAX) begin
      next_period = PERIOD_MAX;
    end else begin
      next_period = cfgInternalBurstPeriod;
    end
  end

  // Configuration store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      burstEnable <= 1'b0;
      burstKindSelect <= 1'b0;
      triggerSource <= SRC_INTERNAL;
      trigOutEnable <= 1'b0;
      sweepOn <= 1'b0;
      modulationOn <= 1'b0;
      phaseDegrees <= PHASE_DEFAULT;
      burstCount <= COUNT_DEFAULT;
      countInfinite <= 1'b0;
      internalBurstPeriod <= PERIOD_DEFAULT;
      trigDelay <= DELAY_DEFAULT_CYC;
      inputEdgeSelect <= 1'b0;
      activeLowGate <= 1'b0;
      outputEdgeSelect <= 1'b0;
    end else if (waveformCommandA) begin
      triggerSource <= SRC_INTERNAL;
    end else if (cfgLoad) begin
      burstEnable <= cfgBurstEnable;
      burstKindSelect <= cfgGatedKind;
      triggerSource <= (cfgSource == SRC_EXTERNAL || cfgSource == SRC_REMOTE) ?
        cfgSource : SRC_INTERNAL;
      trigOutEnable <= cfgTrigOutEnable && !cfgGatedKind &&
        cfgSource != SRC_EXTERNAL;
      sweepOn <= cfgSweepOn && !cfgBurstEnable;
      modulationOn <= cfgModulationOn && !cfgBurstEnable;
      phaseDegrees <= next_phaseDegrees;
      burstCount <= next_count;
      countInfinite <= cfgCountInfinite;
      internalBurstPeriod <= next_period;
      trigDelay <= (cfgDelay > DELAY_MAX) ? DELAY_MAX : cfgDelay;
      inputEdgeSelect <= cfgInputEdgeSelect;
      activeLowGate <= cfgActiveLowGate;
      outputEdgeSelect <= cfgOutputEdgeSelect;
    end
  end

  // Phase handed to the engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enginePhase <= PHASE_DEFAULT;
    end else if (waveShape == SHAPE_PULSE || waveShape == SHAPE_NOISE) begin
      enginePhase <= PHASE_DEFAULT;
    end else begin
      enginePhase <= phaseDegrees;
    end
  end

  // Trigger input
  btc_sync2 extSyncInst (
    .ref_clk(ref_clk),
    .rst(rst),
    .levelIn(extTrigPin),
    .levelOut(extSync)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extPrev <= 1'b0;
    end else begin
      extPrev <= extSync;
    end
  end

  assign extEdge = inputEdgeSelect ? (extPrev && !extSync) : (!extPrev && extSync);
  assign gateActive = extSync ^ activeLowGate;
  assign triggeredOn = burstEnable && !burstKindSelect;

  // Trigger selection, accepted only while idle
  always_comb begin
    fire = 1'b0;
    if (triggeredOn && state == ST_IDLE) begin
      unique case (triggerSource)
        SRC_INTERNAL: fire = (periodCount == unusedLow[PERIOD_W-1:0]);
        SRC_EXTERNAL: fire = extEdge;
        SRC_REMOTE: fire = remoteTrigger;
        default: fire = 1'b0;
      endcase
    end
  end

  // Internal period timer, start to start
  always_ff @(posedge ref_clk) begin
    if (rst || !triggeredOn || triggerSource != SRC_INTERNAL) begin
      periodCount <= unusedLow[PERIOD_W-1:0];
    end else if (periodCount == internalBurstPeriod - 1'b1) begin
      periodCount <= unusedLow[PERIOD_W-1:0];
    end else if (periodCount != unusedLow[PERIOD_W-1:0] || fire) begin
      periodCount <= periodCount + 1'b1;
    end
  end

  assign burstStart = (fire && trigDelay == DELAY_DEFAULT_CYC) ||
    (state == ST_DELAY && delayCount == DELAY_DEFAULT_CYC + 1'b1);

  // Burst sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      waveRun <= 1'b0;
      cyclesDone <= unusedLow[COUNT_W-1:0];
      delayCount <= DELAY_DEFAULT_CYC;
      burstDone <= 1'b0;
    end else begin
      burstDone <= 1'b0;
      if (!burstEnable) begin
        state <= ST_IDLE;
        waveRun <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            cyclesDone <= unusedLow[COUNT_W-1:0];
            if (burstKindSelect) begin
              if (gateActive) begin
                state <= ST_GATE_RUN;
                waveRun <= 1'b1;
              end
            end else if (burstStart) begin
              state <= ST_RUN;
              waveRun <= 1'b1;
            end else if (fire) begin
              state <= ST_DELAY;
              delayCount <= trigDelay;
            end
          end
          ST_DELAY: begin
            delayCount <= delayCount - 1'b1;
            if (burstStart) begin
              state <= ST_RUN;
              waveRun <= 1'b1;
            end
          end
          ST_RUN: begin
            if (cycleEnd) begin
              cyclesDone <= cyclesDone + 1'b1;
              if (!countInfinite && cyclesDone + 1'b1 >= burstCount) begin
                state <= ST_IDLE;
                waveRun <= 1'b0;
                burstDone <= 1'b1;
              end
            end
          end
          ST_GATE_RUN: begin
            if (!gateActive || !burstKindSelect) begin
              if (waveShape == SHAPE_NOISE || cycleEnd) begin
                state <= ST_IDLE;
                waveRun <= 1'b0;
                burstDone <= 1'b1;
              end else begin
                state <= ST_GATE_FINISH;
              end
            end
          end
          ST_GATE_FINISH: begin
            if (cycleEnd || waveShape == SHAPE_NOISE) begin
              state <= ST_IDLE;
              waveRun <= 1'b0;
              burstDone <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Remote waiting indicator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitingForRemote <= 1'b0;
    end else begin
      waitingForRemote <= triggeredOn && triggerSource == SRC_REMOTE &&
        state == ST_IDLE && !fire;
    end
  end

  // Completion flag, the set wins over a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opcPending <= 1'b0;
      eventStatusOpc <= 1'b0;
    end else begin
      if (burstDone && opcPending) begin
        eventStatusOpc <= 1'b1;
      end else if (eventStatusClear) begin
        eventStatusOpc <= 1'b0;
      end
      if (opcRequest) begin
        opcPending <= 1'b1;
      end else if (burstDone) begin
        opcPending <= 1'b0;
      end
    end
  end

  // Trigger output shaping
  always_ff @(posedge ref_clk) begin
    if (rst || triggerSource != SRC_INTERNAL || !triggeredOn) begin
      squareCount <= unusedLow[PERIOD_W-1:0];
      squareRunning <= 1'b0;
    end else if (burstStart) begin
      squareCount <= unusedLow[PERIOD_W-1:0];
      squareRunning <= 1'b1;
    end else if (squareRunning) begin
      squareCount <= (squareCount == internalBurstPeriod - 1'b1) ?
        unusedLow[PERIOD_W-1:0] : squareCount + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulseCount <= 5'h0;
    end else if (burstStart && triggerSource == SRC_REMOTE) begin
      pulseCount <= TRIG_PULSE_CYC;
    end else if (pulseCount != 5'h0) begin
      pulseCount <= pulseCount - 1'b1;
    end
  end

  assign trigAllowed = trigOutEnable && triggeredOn && triggerSource != SRC_EXTERNAL;
  assign trigActive = (triggerSource == SRC_INTERNAL) ?
    (burstStart || (squareRunning && squareCount + 1'b1 < (internalBurstPeriod >> 1))) :
    (burstStart || pulseCount > 5'h1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trigOut <= 1'b0;
    end else if (trigAllowed) begin
      trigOut <= trigActive ^ outputEdgeSelect;
    end else begin
      trigOut <= 1'b0;
    end
  end
endmodule : btc_burst_trigger_controller

//--- logic/btc_pkg.sv
/*
  Constants for the burst and trigger controller: source and shape codes,
  limits, reset values and timing counts.
  Assumes a 25 MHz ref_clk; all time settings arrive as ref_clk cycle counts.
*/
package btc_pkg;
  // Trigger sources
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_REMOTE = 2'h2;
  // Waveform shapes
  localparam logic [2:0] SHAPE_SINE = 3'h0;
  localparam logic [2:0] SHAPE_SQUARE = 3'h1;
  localparam logic [2:0] SHAPE_RAMP = 3'h2;
  localparam logic [2:0] SHAPE_PULSE = 3'h3;
  localparam logic [2:0] SHAPE_NOISE = 3'h4;
  localparam logic [2:0] SHAPE_ARB = 3'h5;
  // Clock
  localparam int CLK_PERIOD_NS = 40;
  // Burst period
  localparam int PERIOD_W = 34;
  localparam int PERIOD_MIN_NS = 1000;
  localparam longint PERIOD_MAX_S = 500;
  localparam longint PERIOD_DEFAULT_NS = 10000000;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN_CYC =
    PERIOD_W'((PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_CYC =
    PERIOD_W'(PERIOD_MAX_S * 64'd1000000000 / CLK_PERIOD_NS);
  localparam logic [PERIOD_W-1:0] PERIOD_DEFAULT_CYC =
    PERIOD_W'(PERIOD_DEFAULT_NS / CLK_PERIOD_NS);
  // Trigger delay
  localparam int DELAY_W = 32;
  localparam longint DELAY_MAX_S = 85;
  localparam logic [DELAY_W-1:0] DELAY_MAX_CYC =
    DELAY_W'(DELAY_MAX_S * 64'd1000000000 / CLK_PERIOD_NS);
  localparam logic [DELAY_W-1:0] DELAY_DEFAULT_CYC = 32'h0;
  // Burst count
  localparam int COUNT_W = 20;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 20'hf4240;
  localparam logic [COUNT_W-1:0] COUNT_DEFAULT = 20'h1;
  // Start phase: degrees in 1/32 steps, radians as Q4.12
  localparam int PHASE_W = 16;
  localparam logic signed [PHASE_W-1:0] PHASE_MAX = 16'sh2d00;
  localparam logic signed [PHASE_W-1:0] PHASE_DEFAULT = 16'sh0;
  localparam logic signed [16:0] RAD_TO_DEG_MUL = 17'sh00729;
  localparam int RAD_FRAC = 12;
  // Remote trigger output pulse, strictly wider than the least width
  localparam int TRIG_PULSE_NS = 1000;
  localparam logic [4:0] TRIG_PULSE_CYC = 5'(TRIG_PULSE_NS / CLK_PERIOD_NS + 1);
  // Standard event status
  localparam int EVENT_OPC_BIT = 0;
endpackage : btc_pkg

//--- logic/btc_sync2.sv
/*
  Two-flop synchroniser for one level.
  Assumes the input may change at any time relative to ref_clk.
*/
`timescale 1ns/1ns
module btc_sync2 (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Level
  input wire logic levelIn,
  output logic levelOut
);
  logic stage1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      levelOut <= 1'b0;
    end else begin
      stage1 <= levelIn;
      levelOut <= stage1;
    end
  end
endmodule : btc_sync2

//--- test/btc_far_side.sv
/*
  Far-side model: external trigger pin, remote host commands and the
  waveform engine's cycle-end pulses.
  Assumes the bench asks for pin levels and host commands through plain requests.
*/
`timescale 1ns/1ns
module btc_far_side #(
  parameter int CYC_LEN = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic pinReq,
  input wire logic hostReq,
  // Device side
  input wire logic waveRun,
  output logic extTrigPin,
  output logic remoteTrigger,
  output logic cycleEnd
);
  logic [7:0] phaseCnt;
  logic hostReqD;
  // Pin edges land unrelated to ref_clk
  assign #7 extTrigPin = pinReq;
  // One command per rising request edge
  always_ff @(posedge ref_clk) begin
    hostReqD <= hostReq;
    remoteTrigger <= hostReq & ~hostReqD;
  end
  // Engine: one cycle end every CYC_LEN cycles of run
  always_ff @(posedge ref_clk) begin
    cycleEnd <= 1'b0;
    if (rst || !waveRun) begin
      phaseCnt <= 8'h0;
    end else if (phaseCnt == 8'(CYC_LEN - 1)) begin
      phaseCnt <= 8'h0;
      cycleEnd <= 1'b1;
    end else begin
      phaseCnt <= phaseCnt + 8'h1;
    end
  end
endmodule : btc_far_side

//--- test/btc_asserts.sv
/*
  Port checks for the burst and trigger controller.
  Assumes one ref_clk domain with synchronous active-high rst.
*/
`timescale 1ns/1ns
module btc_asserts import btc_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic waveformCommandA,
  input wire logic [2:0] waveShape,
  input wire logic burstEnable,
  input wire logic burstKindSelect,
  input wire logic [1:0] triggerSource,
  input wire logic trigOutEnable,
  input wire logic sweepOn,
  input wire logic modulationOn,
  input wire logic signed [PHASE_W-1:0] phaseDegrees,
  input wire logic signed [PHASE_W-1:0] enginePhase,
  input wire logic waveRun,
  input wire logic burstDone,
  input wire logic trigOut,
  input wire logic eventStatusOpc
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_mode_exclusive: assert property (burstEnable |-> !sweepOn && !modulationOn)
    else $error("sweep or modulation on during burst");
  a_trig_out_off: assert property ((burstKindSelect || triggerSource == SRC_EXTERNAL)
    |-> !trigOutEnable) else $error("trigger output left enabled");
  a_ext_quiet: assert property (triggerSource == SRC_EXTERNAL ##1
    triggerSource == SRC_EXTERNAL |-> !trigOut) else $error("trigger output active");
  a_source_legal: assert property (triggerSource != 2'h3)
    else $error("illegal source code");
  a_waveform_command_a_internal: assert property (waveformCommandA |=> triggerSource == SRC_INTERNAL)
    else $error("waveform_command_a did not select internal");
  a_phase_range: assert property (phaseDegrees <= PHASE_MAX && phaseDegrees >= -PHASE_MAX)
    else $error("phase out of range");
  a_phase_ignored: assert property ((waveShape == SHAPE_PULSE || waveShape == SHAPE_NOISE)
    |=> enginePhase == 16'sh0) else $error("phase applied to pulse or noise");
  a_done_stops: assert property (burstDone |-> !waveRun)
    else $error("run continues at burst end");
  a_opc_cause: assert property ($rose(eventStatusOpc) |-> $past(burstDone))
    else $error("completion flag without burst end");
endmodule : btc_asserts
bind btc_burst_trigger_controller btc_asserts btc_asserts_i (.ref_clk(ref_clk), .rst(rst),
  .waveformCommandA(waveformCommandA), .waveShape(waveShape), .burstEnable(burstEnable),
  .burstKindSelect(burstKindSelect), .triggerSource(triggerSource),
  .trigOutEnable(trigOutEnable), .sweepOn(sweepOn), .modulationOn(modulationOn),
  .phaseDegrees(phaseDegrees), .enginePhase(enginePhase), .waveRun(waveRun),
  .burstDone(burstDone), .trigOut(trigOut), .eventStatusOpc(eventStatusOpc));

//--- test/testbench.sv
/*
  Self-checking bench for the burst and trigger controller.
  Assumes a 25 MHz ref_clk and the far-side model for pin, host and engine.
*/
`timescale 1ns/1ns
module testbench import btc_pkg::*;;
  localparam int LIMIT = 20000;
  logic ref_clk, rst, cfgLoad, cfgBurstEnable, cfgGatedKind, cfgCountInfinite;
  logic [1:0] cfgSource;
  logic [COUNT_W-1:0] cfgCount;
  logic [PERIOD_W-1:0] cfgInternalBurstPeriod;
  logic [DELAY_W-1:0] cfgDelay;
  logic signed [PHASE_W-1:0] cfgPhase, phaseDegrees, enginePhase;
  logic cfgUnitRadians, cfgInputEdgeSelect, cfgActiveLowGate, cfgTrigOutEnable;
  logic cfgOutputEdgeSelect, cfgSweepOn, cfgModulationOn, waveformCommandA;
  logic [2:0] waveShape;
  logic extTrigPin, remoteTrigger, opcRequest, eventStatusClear, cycleEnd;
  logic burstEnable, burstKindSelect, trigOutEnable, sweepOn, modulationOn;
  logic [1:0] triggerSource;
  logic waveRun, burstDone, waitingForRemote, trigOut, eventStatusOpc;
  logic pinReq, hostReq, runPrev, endPrev, fallAfterEnd;
  int mismatches, n_compared, seed, cycle, rises, riseAt, lastGap, ends, highs, t0, lat, lat0, p;

  btc_burst_trigger_controller #(.PERIOD_DEFAULT(34'h64)) btc_burst_trigger_controller_i (
    .ref_clk(ref_clk), .rst(rst), .cfgLoad(cfgLoad), .cfgBurstEnable(cfgBurstEnable),
    .cfgGatedKind(cfgGatedKind), .cfgSource(cfgSource), .cfgCount(cfgCount),
    .cfgCountInfinite(cfgCountInfinite), .cfgInternalBurstPeriod(cfgInternalBurstPeriod),
    .cfgDelay(cfgDelay), .cfgPhase(cfgPhase), .cfgUnitRadians(cfgUnitRadians),
    .cfgInputEdgeSelect(cfgInputEdgeSelect), .cfgActiveLowGate(cfgActiveLowGate),
    .cfgTrigOutEnable(cfgTrigOutEnable), .cfgOutputEdgeSelect(cfgOutputEdgeSelect),
    .cfgSweepOn(cfgSweepOn), .cfgModulationOn(cfgModulationOn),
    .waveformCommandA(waveformCommandA), .waveShape(waveShape), .extTrigPin(extTrigPin),
    .remoteTrigger(remoteTrigger), .opcRequest(opcRequest),
    .eventStatusClear(eventStatusClear), .cycleEnd(cycleEnd), .burstEnable(burstEnable),
    .burstKindSelect(burstKindSelect), .triggerSource(triggerSource),
    .trigOutEnable(trigOutEnable), .sweepOn(sweepOn), .modulationOn(modulationOn),
    .phaseDegrees(phaseDegrees), .enginePhase(enginePhase), .waveRun(waveRun),
    .burstDone(burstDone), .waitingForRemote(waitingForRemote), .trigOut(trigOut),
    .eventStatusOpc(eventStatusOpc));
  btc_far_side #(.CYC_LEN(16)) btc_far_side_i (.ref_clk(ref_clk), .rst(rst), .pinReq(pinReq),
    .hostReq(hostReq), .waveRun(waveRun), .extTrigPin(extTrigPin),
    .remoteTrigger(remoteTrigger), .cycleEnd(cycleEnd));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Event monitor
  always @(posedge ref_clk) begin
    cycle <= cycle + 1;
    runPrev <= waveRun;
    endPrev <= cycleEnd;
    if (waveRun && !runPrev) begin
      rises <= rises + 1;
      riseAt <= cycle;
      lastGap <= cycle - riseAt;
    end
    if (!waveRun && runPrev) fallAfterEnd <= endPrev;
    if (cycleEnd && waveRun) ends <= ends + 1;
    if (trigOut) highs <= highs + 1;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : ticks
  task automatic load();
    cfgLoad = 1'b1;
    ticks(1);
    cfgLoad = 1'b0;
    ticks(1);
  endtask : load
  task automatic wait_run(input logic level, input int max);
    int i = 0;
    while (waveRun !== level && i < max) begin
      ticks(1);
      i++;
    end
    check("waveRun", 32'(level), 32'(waveRun));
  endtask : wait_run
  task automatic defaults();
    {cfgBurstEnable, cfgGatedKind, cfgCountInfinite, cfgUnitRadians} = 4'h0;
    {cfgInputEdgeSelect, cfgActiveLowGate, cfgTrigOutEnable, cfgOutputEdgeSelect} = 4'h0;
    {cfgSweepOn, cfgModulationOn} = 2'h0;
    cfgSource = SRC_INTERNAL;
    cfgCount = 20'h1;
    cfgInternalBurstPeriod = 34'h64;
    cfgDelay = 32'h0;
    cfgPhase = 16'sh0;
  endtask : defaults
  function automatic int exp_phase(input int v, input bit rad);
    int d;
    d = rad ? (v * 1833) >>> 12 : v;
    if (d > 11520) d = 11520;
    if (d < -11520) d = -11520;
    return d;
  endfunction : exp_phase
  task automatic remote_burst(input logic [31:0] dly);
    defaults();
    cfgSource = SRC_REMOTE;
    cfgCount = 20'h3;
    cfgTrigOutEnable = 1'b1;
    cfgBurstEnable = 1'b1;
    cfgDelay = dly;
    load();
    ticks(4);
    check("waitingForRemote", 32'h1, 32'(waitingForRemote));
    check("idle run", 32'h0, 32'(waveRun));
    {rises, ends, highs} = '0;
    hostReq = 1'b1;
    t0 = cycle;
    wait_run(1'b1, 100);
    lat = cycle - t0;
    hostReq = 1'b0;
    wait_run(1'b0, 200);
    ticks(30);
    check("cycles", 32'h3, 32'(ends));
    check("pulse width", 32'd26, 32'(highs));
  endtask : remote_burst

  initial begin
    repeat (LIMIT) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'h9f23b667;
    {mismatches, n_compared, cycle, rises, riseAt, lastGap, ends, highs} = '0;
    {rst, runPrev, endPrev, fallAfterEnd, pinReq, hostReq} = 6'h20;
    {cfgLoad, waveformCommandA, opcRequest, eventStatusClear} = 4'h0;
    waveShape = SHAPE_SINE;
    defaults();
    ticks(4);
    rst = 1'b0;
    ticks(1);
    check("burstEnable", 32'h0, 32'(burstEnable));
    check("trigOutEnable", 32'h0, 32'(trigOutEnable));
    check("triggerSource", 32'(SRC_INTERNAL), 32'(triggerSource));
    check("phaseDegrees", 32'h0, 32'(phaseDegrees));
    {cfgSweepOn, cfgModulationOn} = 2'h3;
    load();
    check("sweepOn", 32'h1, 32'(sweepOn));
    cfgBurstEnable = 1'b1;
    load();
    check("sweepOn", 32'h0, 32'(sweepOn));
    check("modulationOn", 32'h0, 32'(modulationOn));
    $display("test defaults done");
    defaults();
    for (int i = 0; i < 10; i++) begin
      cfgUnitRadians = (i < 8) ? i[0] : 1'b0;
      p = (i == 8) ? 32767 : (i == 9) ? -32768 : $random(seed) % (i[0] ? 25736 : 11521);
      cfgPhase = PHASE_W'(p);
      load();
      check("phaseDegrees", 32'(exp_phase(p, cfgUnitRadians)), 32'(phaseDegrees));
    end
    $display("test phase done");
    cfgTrigOutEnable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      cfgSource = s[1:0];
      load();
      check("triggerSource", (s == 3) ? 32'h0 : 32'(s), 32'(triggerSource));
      check("trigOutEnable", 32'(s != 1), 32'(trigOutEnable));
    end
    cfgGatedKind = 1'b1;
    cfgSource = SRC_REMOTE;
    load();
    check("gated trigOutEnable", 32'h0, 32'(trigOutEnable));
    waveformCommandA = 1'b1;
    ticks(1);
    waveformCommandA = 1'b0;
    ticks(1);
    check("applied source", 32'(SRC_INTERNAL), 32'(triggerSource));
    $display("test sources done");
    opcRequest = 1'b1;
    ticks(1);
    opcRequest = 1'b0;
    remote_burst(32'h0);
    lat0 = lat;
    check("eventStatusOpc", 32'h1, 32'(eventStatusOpc));
    p = 1 + {$random(seed)} % 40;
    remote_burst(32'(p));
    check("delay", 32'(lat0 + p), 32'(lat));
    eventStatusClear = 1'b1;
    ticks(1);
    eventStatusClear = 1'b0;
    check("cleared opc", 32'h0, 32'(eventStatusOpc));
    $display("test remote done");
    defaults();
    cfgSource = SRC_EXTERNAL;
    cfgCount = 20'h2;
    cfgBurstEnable = 1'b1;
    load();
    {rises, ends} = '0;
    pinReq = 1'b1;
    wait_run(1'b1, 20);
    ticks(3);
    pinReq = 1'b0;
    ticks(3);
    pinReq = 1'b1;
    wait_run(1'b0, 100);
    ticks(10);
    check("bursts", 32'h1, 32'(rises));
    check("cycles", 32'h2, 32'(ends));
    cfgInputEdgeSelect = 1'b1;
    load();
    rises = 0;
    pinReq = 1'b0;
    wait_run(1'b1, 20);
    wait_run(1'b0, 100);
    check("falling bursts", 32'h1, 32'(rises));
    $display("test external done");
    defaults();
    p = 40 + 2 * ({$random(seed)} % 30);
    cfgInternalBurstPeriod = PERIOD_W'(p);
    cfgTrigOutEnable = 1'b1;
    cfgBurstEnable = 1'b1;
    load();
    ticks(3 * p + 10);
    check("period", 32'(p), 32'(lastGap));
    highs = 0;
    ticks(p);
    check("square high", 32'(p / 2), 32'(highs));
    $display("test internal done");
    defaults();
    pinReq = 1'b1;
    load();
    {cfgGatedKind, cfgActiveLowGate, cfgBurstEnable} = 3'h7;
    load();
    ticks(5);
    check("gate false run", 32'h0, 32'(waveRun));
    pinReq = 1'b0;
    wait_run(1'b1, 10);
    ticks(40);
    pinReq = 1'b1;
    wait_run(1'b0, 40);
    ticks(1);
    check("stop at cycle end", 32'h1, 32'(fallAfterEnd));
    waveShape = SHAPE_NOISE;
    pinReq = 1'b0;
    wait_run(1'b1, 10);
    ticks(7);
    pinReq = 1'b1;
    wait_run(1'b0, 6);
    $display("test gated done");
    final_report();
  end
endmodule : testbench
